// [include/nibble_bus_pkg.sv]
// Purpose: Shared constants and types for the nibble bus peripheral port
// Assumes: 4-bit bus, 20-bit pointers, five-nibble pointer and config loads
// Notes:   Command codes follow the bus command table
package nibble_bus_pkg;

  localparam int          NIB_W        = 4;
  localparam int          ADDR_W       = 20;
  localparam int          LOAD_NIBS    = 5;
  localparam logic [2:0]  LAST_NIB_IDX = 3'h4;
  localparam int          AUTO_SW_BIT  = 2;
  localparam int          POLL_LINE    = 0;

  // Bus command codes
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_ENUM_QUERY = 4'h1;
  localparam logic [3:0] CMD_PROG_FETCH = 4'h2;
  localparam logic [3:0] CMD_DATA_FETCH = 4'h3;
  localparam logic [3:0] CMD_TEST_SET   = 4'h4;
  localparam logic [3:0] CMD_DATA_STORE = 4'h5;
  localparam logic [3:0] CMD_PROG_FILL  = 4'h6;
  localparam logic [3:0] CMD_DATA_FILL  = 4'h7;
  localparam logic [3:0] CMD_ASSIGN     = 4'h8;
  localparam logic [3:0] CMD_RELEASE    = 4'h9;
  localparam logic [3:0] CMD_POLL       = 4'hA;
  localparam logic [3:0] CMD_RSVD_B     = 4'hB;
  localparam logic [3:0] CMD_DEV_SPEC   = 4'hC;
  localparam logic [3:0] CMD_RSVD_D     = 4'hD;
  localparam logic [3:0] CMD_SHUTDOWN   = 4'hE;
  localparam logic [3:0] CMD_BUS_RESET  = 4'hF;

  // Reset values
  localparam logic [3:0]        CMD_RESET  = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_RESET  = 20'h00000;
  localparam logic [3:0]        TEST_RESET = 4'h0;

  // Memory-side request toward the local storage
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [NIB_W-1:0]  data;
  } mem_req_s;

endpackage

// [src/nibble_bus_peripheral_port.sv]
// Purpose: Peripheral side of a 4-bit multiplexed command/address/data bus
// Assumes: Strobe, select and bus lines are asynchronous pins sampled by ref_clk_i
// Notes:   Local storage is an internal nibble array of 2**SPACE_W entries
//
// Overview of operation
// R1 - Drive bus on strobe low, capture on rise
// R2 - Command strobe loads held command
// R3 - Held command governs later data strobes
// R4 - Code 0 ignores strobes until new command
// R5 - Code 1 unconfigured chained device returns identification
// R6 - Codes 2/3 read at pointer, increment
// R7 - Code 4 loads test setting register
// R8 - Code 5 stores nibble at data pointer
// R9 - Codes 6/7 fill pointers, low nibble first
// R10 - Fifth pointer nibble clears command bit 2
// R11 - Dummy strobe after reads: no increment
// R12 - Code 8 loads configuration when chain high
// R13 - Code 9 releases matching configured device
// R14 - Master loads data pointer before release
// R15 - Code A pulls one line when service needed
// R16 - Codes B, C, D act as no-operation
// R17 - Code E leaves device unaffected here
// R18 - Code F clears configuration flag
// R19 - Respond only on upper-pointer bits matching configuration
// R20 - Unconfigured after reset, chain output low
// R21 - Configured copies chain; flag set next command
// R22 - Master precharges bus low each strobe
// R23 - Hard-configured mode has fixed address
// R24 - External reset clears command and flag
`timescale 1ns/1ps
module nibble_bus_peripheral_port #(
  parameter int                 SPACE_W   = 11,
  parameter bit                 HARD_CFG  = 1'b0,
  parameter logic [19:0]        HARD_ADDR = 20'h00000,
  parameter logic [19:0]        DEV_ID    = 20'h12345  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Bus pins
  input  wire logic       bus_strobe_n_i,
  input  wire logic       command_select_n_i,
  input  wire logic [3:0] bus_data_i,
  output logic      [3:0] bus_data_o,
  output logic      [3:0] bus_data_oe_o,
  // Daisy chain
  input  wire logic       chain_in_i,
  output logic            chain_out_o,
  // Local status
  input  wire logic       service_req_i,
  output logic      [3:0] test_setting_o,
  output logic            configured_o
);
  // Configuration width left above the local space
  localparam int CFG_W = 20 - SPACE_W;

  // The nibble-wise configuration shift needs at least five kept bits
  initial begin
    if (SPACE_W < 1 || SPACE_W > 15) begin
      $error("SPACE_W out of range");
    end
  end

  // Pin synchronisers: chain, strobe, select, nibble; only the second stage is read
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic       strobe_d_reg;
  always_ff @(posedge ref_clk_i) begin
    sync1_reg    <= {chain_in_i, bus_strobe_n_i, command_select_n_i, bus_data_i};
    sync2_reg    <= sync1_reg;
    strobe_d_reg <= rst_i ? 1'b1 : sync2_reg[5];  // Idle level high, no false edge after reset
  end

  // Synchronised pins and strobe edges
  wire       strobe_s = sync2_reg[5];
  wire       cmd_sel  = ~sync2_reg[4];
  wire [3:0] nib      = sync2_reg[3:0];
  wire       chain_s  = sync2_reg[6];
  wire       fall     = strobe_d_reg & ~strobe_s;
  wire       rise     = ~strobe_d_reg & strobe_s;  // R1

  // State
  logic [3:0]         cmd_reg;
  logic [19:0]        pc_reg, dp_reg, id_sh_reg;
  logic [CFG_W-1:0]   cfg_reg;
  logic               cfg_flag_reg, cfg_pend_reg, dummy_reg, cmd_strobe_reg;
  logic [2:0]         cnt_reg;
  logic [3:0]         test_reg, dout_reg, doe_reg;
  logic [3:0]         mem [0:(1<<SPACE_W)-1];

  function automatic logic match(input logic [19:0] a, input logic [CFG_W-1:0] c);
    match = (a[19:SPACE_W] == c);
  endfunction

  // Keeps only high-order configuration bits as nibbles shift in
  function automatic logic [CFG_W-5:0] cfg_reg_shift(input logic [CFG_W-1:0] c);
    cfg_reg_shift = c[CFG_W-1:4];
  endfunction

  // Decoding
  wire [CFG_W-1:0] cfg_eff  = HARD_CFG ? HARD_ADDR[19:SPACE_W] : cfg_reg;
  wire       is_cfg   = HARD_CFG | cfg_flag_reg;
  wire       pc_hit   = is_cfg & match(pc_reg, cfg_eff);  // R19
  wire       dp_hit   = is_cfg & match(dp_reg, cfg_eff);  // R19
  wire       chain_ok = ~is_cfg & chain_s & ~cfg_pend_reg;  // R21

  // Strobe classification: data strobes exclude command and dummy strobes
  wire       dstrobe  = rise & ~cmd_strobe_reg & ~dummy_reg;
  wire       is_fill  = (cmd_reg == nibble_bus_pkg::CMD_PROG_FILL) | (cmd_reg == nibble_bus_pkg::CMD_DATA_FILL);
  wire       is_fetch = (cmd_reg == nibble_bus_pkg::CMD_PROG_FETCH) | (cmd_reg == nibble_bus_pkg::CMD_DATA_FETCH);
  wire       incr     = dstrobe & (is_fetch | cmd_reg == nibble_bus_pkg::CMD_DATA_STORE);  // R6 R8 R11
  wire       last_nib = dstrobe & (cnt_reg == nibble_bus_pkg::LAST_NIB_IDX);

  // Pointer fill shifts, local offsets and the poll line
  wire [19:0] shift_in_pc = {nib, pc_reg[19:4]};
  wire [19:0] shift_in_dp = {nib, dp_reg[19:4]};
  wire [SPACE_W-1:0] pc_off = pc_reg[SPACE_W-1:0];
  wire [SPACE_W-1:0] dp_off = dp_reg[SPACE_W-1:0];
  wire [3:0]  poll_mask   = 4'(4'h1 << nibble_bus_pkg::POLL_LINE);

  // Read drive, decided at strobe fall
  logic [3:0] drv_data;
  logic       drv_en;
  always_comb begin
    drv_data = 4'h0;
    drv_en   = 1'b0;
    unique case (cmd_reg)
      nibble_bus_pkg::CMD_ENUM_QUERY: begin  // R5
        drv_en   = chain_ok & (cnt_reg < 3'h5) & ~HARD_CFG;
        drv_data = id_sh_reg[3:0];
      end
      nibble_bus_pkg::CMD_PROG_FETCH: begin  // R6
        drv_en   = pc_hit & ~dummy_reg;
        drv_data = mem[pc_off];
      end
      nibble_bus_pkg::CMD_DATA_FETCH: begin  // R6
        drv_en   = dp_hit & ~dummy_reg;
        drv_data = mem[dp_off];
      end
      nibble_bus_pkg::CMD_POLL: begin  // R15
        drv_en   = service_req_i & (cnt_reg == 3'h0);  // First strobe after the command only
        drv_data = poll_mask;
      end
      default: begin  // R4 R16 R17
        drv_en   = 1'b0;
        drv_data = 4'h0;
      end
    endcase
  end

  // Enable pattern: a poll answer holds one line, a read holds all four
  wire [3:0] drv_mask = (cmd_reg == nibble_bus_pkg::CMD_POLL) ? poll_mask : 4'hF;

  // Bus output stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || rise) begin
      doe_reg  <= 4'h0;
      dout_reg <= 4'h0;
    end else if (fall && !cmd_sel) begin  // R1
      doe_reg  <= drv_en ? drv_mask : 4'h0;
      dout_reg <= drv_data;
    end
  end

  // Command and sequencing
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin  // R24
      cmd_reg        <= nibble_bus_pkg::CMD_RESET;
      cfg_flag_reg   <= 1'b0;  // R20
      cfg_pend_reg   <= 1'b0;
      cnt_reg        <= 3'h0;
      dummy_reg      <= 1'b0;
      cmd_strobe_reg <= 1'b0;
    end else if (fall) begin
      cmd_strobe_reg <= cmd_sel;
    end else if (rise && cmd_strobe_reg) begin  // R2
      cmd_reg   <= nib;
      cnt_reg   <= 3'h0;
      dummy_reg <= (nib == nibble_bus_pkg::CMD_PROG_FETCH) | (nib == nibble_bus_pkg::CMD_DATA_FETCH);  // R11
      if (cfg_pend_reg) begin  // R21
        cfg_flag_reg <= 1'b1;
        cfg_pend_reg <= 1'b0;
      end
      if (nib == nibble_bus_pkg::CMD_BUS_RESET && !HARD_CFG) cfg_flag_reg <= 1'b0;  // R18
      if (nib == nibble_bus_pkg::CMD_RELEASE && !HARD_CFG && dp_hit) cfg_flag_reg <= 1'b0;  // R13 R14
    end else if (rise) begin  // R3
      dummy_reg <= 1'b0;
      if (dstrobe && cnt_reg != 3'h7) cnt_reg <= cnt_reg + 3'h1;
      if (last_nib && is_fill) begin  // R10
        cmd_reg[nibble_bus_pkg::AUTO_SW_BIT] <= 1'b0;
        dummy_reg <= 1'b1;  // R11
      end
      if (last_nib && cmd_reg == nibble_bus_pkg::CMD_ASSIGN && chain_ok && !HARD_CFG) cfg_pend_reg <= 1'b1;  // R12
    end
  end

  // Pointers, configuration, identification, test setting
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_reg    <= nibble_bus_pkg::PTR_RESET;
      dp_reg    <= nibble_bus_pkg::PTR_RESET;
      cfg_reg   <= '0;
      test_reg  <= nibble_bus_pkg::TEST_RESET;
      id_sh_reg <= DEV_ID;
    end else if (rise && cmd_strobe_reg) begin
      id_sh_reg <= DEV_ID;
    end else if (dstrobe) begin
      unique case (cmd_reg)
        nibble_bus_pkg::CMD_PROG_FILL:  if (cnt_reg < 3'h5) pc_reg <= shift_in_pc;  // R9
        nibble_bus_pkg::CMD_DATA_FILL:  if (cnt_reg < 3'h5) dp_reg <= shift_in_dp;  // R9
        nibble_bus_pkg::CMD_TEST_SET:   test_reg <= nib;  // R7
        nibble_bus_pkg::CMD_ENUM_QUERY: id_sh_reg <= {4'h0, id_sh_reg[19:4]};  // R5
        nibble_bus_pkg::CMD_ASSIGN: begin  // R12
          if (chain_ok && cnt_reg < 3'h5) cfg_reg <= {nib, cfg_reg_shift(cfg_reg)};
        end
        default: ;
      endcase
      if (incr && cmd_reg == nibble_bus_pkg::CMD_PROG_FETCH) pc_reg <= pc_reg + 20'h00001;  // R6
      if (incr && cmd_reg != nibble_bus_pkg::CMD_PROG_FETCH) dp_reg <= dp_reg + 20'h00001;  // R6 R8
    end
  end

  // Storage request: only the addressed device writes, once per data strobe
  nibble_bus_pkg::mem_req_s store_req;
  assign store_req = '{wr:   incr & (cmd_reg == nibble_bus_pkg::CMD_DATA_STORE) & dp_hit,  // R8
                       addr: dp_reg,
                       data: nib};

  // Local storage write
  always_ff @(posedge ref_clk_i) begin
    if (store_req.wr) begin
      mem[store_req.addr[SPACE_W-1:0]] <= store_req.data;  // R8
    end
  end

  // Outputs
  assign bus_data_o     = dout_reg;
  assign bus_data_oe_o  = doe_reg;
  assign test_setting_o = test_reg;
  assign configured_o   = cfg_flag_reg;
  logic chain_out_reg;
  always_ff @(posedge ref_clk_i) begin
    chain_out_reg <= rst_i ? 1'b0 : (is_cfg & chain_s);  // R20 R21 R23
  end
  assign chain_out_o = chain_out_reg;

  // Reset and configuration checks
  a_reset_clears_cmd: assert property (@(posedge ref_clk_i) rst_i |=> cmd_reg == 4'h0 && !cfg_flag_reg)  // R24
    else $error("reset left command or flag");
  a_bus_reset_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R18
    rise && cmd_strobe_reg && nib == 4'hF && !cfg_pend_reg |=> !cfg_flag_reg)
    else $error("bus reset kept configuration");
  a_release_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R13
    rise && cmd_strobe_reg && nib == nibble_bus_pkg::CMD_RELEASE && dp_hit && !HARD_CFG |=> !cfg_flag_reg)
    else $error("release kept configuration");
  a_flag_waits: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R21
    $rose(cfg_flag_reg) |-> $past(rise) && $past(cmd_strobe_reg))
    else $error("flag set outside a command strobe");
  a_unconf_chain_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R20
    !is_cfg |=> !chain_out_o)
    else $error("chain out high while unconfigured");
  a_chain_copy: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R21
    is_cfg |=> chain_out_o == $past(chain_s))
    else $error("chain out does not follow chain in");

  // Sequencing checks
  a_auto_switch: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R10
    last_nib && is_fill && !cmd_strobe_reg |=> !cmd_reg[2] && dummy_reg)
    else $error("auto switch missing");
  a_dummy_no_incr: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R11
    rise && dummy_reg |=> $stable(pc_reg) && $stable(dp_reg))
    else $error("pointer moved on dummy strobe");
  a_cmd_no_move: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R2
    rise && cmd_strobe_reg |=> $stable(pc_reg) && $stable(dp_reg))
    else $error("pointer moved on command strobe");
  a_dp_fill_shift: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R9
    dstrobe && cmd_reg == nibble_bus_pkg::CMD_DATA_FILL |=> dp_reg[19:16] == $past(nib))
    else $error("data pointer fill lost a nibble");
  a_pc_fill_shift: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R9
    dstrobe && cmd_reg == nibble_bus_pkg::CMD_PROG_FILL |=> pc_reg[19:16] == $past(nib))
    else $error("program pointer fill lost a nibble");
  a_test_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R7
    dstrobe && cmd_reg == 4'h4 |=> test_setting_o == $past(nib))
    else $error("test setting not loaded");

  // Bus drive checks
  a_nop_silent: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R4
    cmd_reg == 4'h0 && !cmd_strobe_reg |=> bus_data_oe_o == 4'h0)
    else $error("drive during no-operation");
  a_drive_released: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R1
    rise |=> bus_data_oe_o == 4'h0)
    else $error("bus driven after strobe rise");
  a_fetch_needs_hit: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R19
    fall && !cmd_sel && cmd_reg == nibble_bus_pkg::CMD_DATA_FETCH && !dp_hit |=> bus_data_oe_o == 4'h0)
    else $error("read answered outside own space");
  a_id_needs_chain: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R5
    fall && !cmd_sel && cmd_reg == nibble_bus_pkg::CMD_ENUM_QUERY && !chain_ok |=> bus_data_oe_o == 4'h0)
    else $error("identification sent without chain grant");
  a_poll_one_line: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // R15
    cmd_reg == nibble_bus_pkg::CMD_POLL && bus_data_oe_o != 4'h0
    |-> bus_data_oe_o == poll_mask && bus_data_o == poll_mask)
    else $error("poll answer not on one line");

  // Main scenarios
  c_fill_then_fetch: cover property (@(posedge ref_clk_i) last_nib && is_fill);
  c_assign_done: cover property (@(posedge ref_clk_i) cfg_pend_reg ##1 cfg_flag_reg);
  c_poll_drive: cover property (@(posedge ref_clk_i) cmd_reg == 4'hA && bus_data_oe_o != 4'h0);
  c_release_done: cover property (@(posedge ref_clk_i)
    rise && cmd_strobe_reg && nib == nibble_bus_pkg::CMD_RELEASE && dp_hit);
endmodule

// [verification/nibble_bus_master_model.sv]
// Purpose: Behavioural bus master that drives strobe, select and nibbles
// Assumes: Strobe low 480 ns and high 320 ns, one 800 ns cycle per transfer
// Notes:   Strobe stands high between transfers; read nibbles pulse out
`timescale 1ns/1ps
module nibble_bus_master_model (
  // Bus pins
  output logic            strobe_n_o,
  output logic            select_n_o,
  output logic      [3:0] data_o,
  output logic            oe_o,
  input  wire logic [3:0] bus_i,
  // Captured read nibbles
  output logic            rd_pulse_o,
  output logic      [3:0] rd_data_o
);
  // Idle levels
  initial begin
    strobe_n_o = 1'b1;
    select_n_o = 1'b1;
    data_o     = 4'h0;
    oe_o       = 1'b0;
    rd_pulse_o = 1'b0;
    rd_data_o  = 4'h0;
  end

  // One strobe: hold past the rise, set up, low phase, capture at the rise
  task automatic xfer(input logic cmd, input logic [3:0] val, input logic drv, input logic smp);
    #300;
    select_n_o = ~cmd;
    oe_o       = drv;
    data_o     = val;
    #10;
    strobe_n_o = 1'b0;
    #480;
    rd_data_o  = bus_i;
    rd_pulse_o = smp;
    strobe_n_o = 1'b1;
    #10;
    rd_pulse_o = 1'b0;
  endtask

  // Transfer kinds
  task automatic cmd(input logic [3:0] code);
    xfer(1'b1, code, 1'b1, 1'b0);
  endtask
  task automatic wr(input logic [3:0] nib);
    xfer(1'b0, nib, 1'b1, 1'b0);
  endtask
  task automatic rd;
    xfer(1'b0, 4'h0, 1'b0, 1'b1);
  endtask
  task automatic dummy;
    xfer(1'b0, 4'h0, 1'b0, 1'b0);
  endtask
endmodule

// [verification/nibble_bus_peripheral_port_bench.sv]
// Purpose: Self-checking bench for the nibble bus peripheral port
// Assumes: 2K-nibble space, soft configuration, master model on the bus
// Notes:   Read nibbles are compared in order against a queue of expectations
`timescale 1ns/1ps
module nibble_bus_peripheral_port_bench;
  localparam logic [19:0] ID_VAL = 20'h6B2D9; // Arbitrary value
  localparam logic [19:0] BASE   = 20'h3A800;
  logic       ref_clk_i     = 1'b0;
  logic       rst_i         = 1'b1;
  logic       chain_in_i    = 1'b0;
  logic       service_req_i = 1'b0;
  logic       strobe_n, select_n, mst_oe, rd_pulse, chain_out, configured;
  logic [3:0] mst_data, rd_data, dut_data, dut_oe, test_setting;
  logic [3:0] img [0:15];
  logic [3:0] exp_q [$];
  int         mismatches = 0;
  int         cmp_count  = 0;
  // Undriven lines sit at the precharge level
  wire  [3:0] bus_wire = (dut_oe & dut_data) | (mst_oe ? mst_data : 4'h0);

  always #50 ref_clk_i = ~ref_clk_i;

  nibble_bus_master_model master (.strobe_n_o(strobe_n), .select_n_o(select_n), .data_o(mst_data),
    .oe_o(mst_oe), .bus_i(bus_wire), .rd_pulse_o(rd_pulse), .rd_data_o(rd_data));

  nibble_bus_peripheral_port #(.DEV_ID(ID_VAL)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_strobe_n_i(strobe_n), .command_select_n_i(select_n),
    .bus_data_i(bus_wire), .bus_data_o(dut_data), .bus_data_oe_o(dut_oe), .chain_in_i(chain_in_i),
    .chain_out_o(chain_out), .service_req_i(service_req_i), .test_setting_o(test_setting),
    .configured_o(configured));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic settle;
    repeat (5) @(posedge ref_clk_i);
    #5;
  endtask
  task automatic load20(input logic [3:0] code, input logic [19:0] val);
    master.cmd(code);
    for (int i = 0; i < 5; i++) master.wr(val[4*i +: 4]);
  endtask
  task automatic expect_rd(input logic [3:0] nib);
    exp_q.push_back(nib);
    master.rd();
  endtask

  // Each captured read nibble is matched to the oldest note
  always @(posedge rd_pulse) begin
    if (exp_q.size() == 0) check({4'h0, rd_data}, 8'hFF);
    else check({4'h0, rd_data}, {4'h0, exp_q.pop_front()});
  end

  initial begin
    #2_000_000;
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(32'h92c67063));
    for (int i = 0; i < 16; i++) img[i] = 4'($urandom());
    repeat (12) @(posedge ref_clk_i);
    #5 rst_i = 1'b0;
    settle();
    check({7'h0, configured}, 8'h00);
    check({7'h0, chain_out}, 8'h00);
    // Identify with chain low, then high
    master.cmd(nibble_bus_pkg::CMD_ENUM_QUERY);
    for (int i = 0; i < 5; i++) expect_rd(4'h0);
    chain_in_i = 1'b1;
    master.cmd(nibble_bus_pkg::CMD_ENUM_QUERY);
    for (int i = 0; i < 5; i++) expect_rd(ID_VAL[4*i +: 4]);
    check({7'h0, chain_out}, 8'h00);
    // Assign; the flag waits for the next command strobe
    load20(nibble_bus_pkg::CMD_ASSIGN, BASE);
    settle();
    check({7'h0, configured}, 8'h00);
    master.cmd(nibble_bus_pkg::CMD_NOP);
    settle();
    check({7'h0, configured}, 8'h01);
    check({7'h0, chain_out}, 8'h01);
    master.cmd(nibble_bus_pkg::CMD_ENUM_QUERY);
    for (int i = 0; i < 5; i++) expect_rd(4'h0);
    // Store across the top of the space, read back after auto-switch
    load20(nibble_bus_pkg::CMD_DATA_FILL, BASE + 20'h007F0);
    master.dummy();
    master.cmd(nibble_bus_pkg::CMD_DATA_STORE);
    for (int i = 0; i < 18; i++) master.wr(i < 16 ? img[i] : 4'hC);
    load20(nibble_bus_pkg::CMD_DATA_FILL, BASE + 20'h007F0);
    master.dummy();
    for (int i = 0; i < 18; i++) expect_rd(i < 16 ? img[i] : 4'h0);
    load20(nibble_bus_pkg::CMD_PROG_FILL, BASE + 20'h007F8);
    master.dummy();
    for (int i = 8; i < 12; i++) expect_rd(img[i]);
    master.cmd(nibble_bus_pkg::CMD_PROG_FETCH);
    master.dummy();
    for (int i = 12; i < 14; i++) expect_rd(img[i]);
    // Test setting, then codes that must change nothing
    master.cmd(nibble_bus_pkg::CMD_TEST_SET);
    master.wr(4'h9);
    settle();
    check({4'h0, test_setting}, 8'h09);
    foreach (img[k]) if (k inside {0, 11, 12, 13, 14}) begin
      master.cmd(4'(k));
      master.wr(4'h6);
      settle();
      check({3'h0, configured, test_setting}, 8'h19);
    end
    // Service poll
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk_i);
      #5 service_req_i = s[0];
      master.cmd(nibble_bus_pkg::CMD_POLL);
      expect_rd({3'h0, s[0]});
    end
    // Release: elsewhere ignored, own space honoured
    load20(nibble_bus_pkg::CMD_DATA_FILL, BASE ^ 20'h80000);
    master.dummy();
    master.cmd(nibble_bus_pkg::CMD_RELEASE);
    settle();
    check({7'h0, configured}, 8'h01);
    load20(nibble_bus_pkg::CMD_DATA_FILL, BASE + 20'h00003);
    master.dummy();
    master.cmd(nibble_bus_pkg::CMD_RELEASE);
    settle();
    check({6'h0, configured, chain_out}, 8'h00);
    // Bus reset, then external reset in mid-run
    load20(nibble_bus_pkg::CMD_ASSIGN, BASE);
    master.cmd(nibble_bus_pkg::CMD_NOP);
    settle();
    check({7'h0, configured}, 8'h01);
    master.cmd(nibble_bus_pkg::CMD_BUS_RESET);
    settle();
    check({7'h0, configured}, 8'h00);
    load20(nibble_bus_pkg::CMD_ASSIGN, BASE);
    master.cmd(nibble_bus_pkg::CMD_TEST_SET);
    settle();
    rst_i = 1'b1;
    settle();
    rst_i = 1'b0;
    master.wr(4'h5);
    settle();
    check({3'h0, configured, test_setting}, 8'h00);
    check(8'(exp_q.size()), 8'h00);
    summarize();
  end
endmodule
